// ==== cja_params.svh ====
`ifndef CJA_PARAMS_SVH
`define CJA_PARAMS_SVH

// Opcode patterns (full bytes, or masked forms below).
`define OPC_CALL_LOW5      5'h11
`define OPC_JUMP_LOW5      5'h01
`define OPC_ADD_REG_HI5    5'h05
`define OPC_ADD_DIR        8'h25
`define OPC_ADD_IND_HI7    7'h13
`define OPC_ADD_IMM        8'h24
`define OPC_ADD_WITH_CARRY_OP_REG_HI5   5'h07
`define OPC_ADD_WITH_CARRY_OP_DIR       8'h35
`define OPC_ADD_WITH_CARRY_OP_IND_HI7   7'h1B
`define OPC_ADD_WITH_CARRY_OP_IMM       8'h34
`define OPC_AND_REG_HI5    5'h0B
`define OPC_AND_DIR        8'h55
`define OPC_AND_IND_HI7    7'h2B
`define OPC_AND_IMM        8'h54
`define OPC_AND_DIR_A      8'h52
`define OPC_AND_DIR_IMM    8'h53

// Direct addresses at and above this value are hardware registers.
`define SFR_BASE           8'h80
// Direct addresses of the output port latches.
`define PORT0_ADDR         8'h80
`define PORT1_ADDR         8'h90
`define PORT2_ADDR         8'hA0
`define PORT3_ADDR         8'hB0

// Reset values.
`define SP_RESET           8'h07
`define PC_RESET           16'h0000
`define ACC_RESET          8'h00
`define PORT_RESET         8'hFF

// Block size covered by an absolute call or jump, as low address bits.
`define PAGE_BITS          11

`endif

// ==== cja_pkg.sv ====
package cja_pkg;

   typedef enum logic [1:0] {
      ST_FETCH   = 2'b00,
      ST_OPERAND = 2'b01,
      ST_EXEC    = 2'b10,
      ST_SECOND  = 2'b11
   } exec_state_t;

   typedef enum logic [3:0] {
      OP_NONE     = 4'h0,
      OP_CALL     = 4'h1,
      OP_JUMP     = 4'h2,
      OP_ADD      = 4'h3,
      OP_ADD_WITH_CARRY_OP     = 4'h4,
      OP_AND_A    = 4'h5,
      OP_AND_DA   = 4'h6,
      OP_AND_DI   = 4'h7
   } op_kind_t;

   typedef enum logic [1:0] {
      SRC_REG = 2'b00,
      SRC_DIR = 2'b01,
      SRC_IND = 2'b10,
      SRC_IMM = 2'b11
   } src_kind_t;

endpackage

// ==== byte_adder.sv ====
`timescale 1ns/1ns
`include "cja_params.svh"

module byte_adder
   import cja_pkg::*;
(
   // Operands
   input  wire logic [7:0] accIn,
   input  wire logic [7:0] srcIn,
   input  wire logic       carryIn,
   // Result and flags
   output logic [7:0]      sumOut,
   output logic            carryOut,
   output logic            auxOut,
   output logic            ovfOut
);

   logic [4:0] lowNib;
   logic [3:0] midBits;
   logic [1:0] topBit;

   // The sum is split at bit 3 and bit 6 so both internal carries are visible.
   always_comb begin
      lowNib   = {1'b0, accIn[3:0]} + {1'b0, srcIn[3:0]} + {4'h0, carryIn};
      midBits  = {1'b0, accIn[6:4]} + {1'b0, srcIn[6:4]} + {3'h0, lowNib[4]};
      topBit   = {1'b0, accIn[7]} + {1'b0, srcIn[7]} + {1'b0, midBits[3]};
      sumOut   = {topBit[0], midBits[2:0], lowNib[3:0]};
      carryOut = topBit[1];
      auxOut   = lowNib[4];
      ovfOut   = topBit[1] ^ midBits[3];
   end

endmodule

// ==== call_jump_add_and_executor.sv ====
`timescale 1ns/1ns
`include "cja_params.svh"

// Function
// - Absolute call advances PC by two, pushes low then high return byte.
// - Absolute call leaves flags alone; low return byte sits lower on stack.
// - Absolute jump target joins PC top five bits, opcode 7-5, second byte.
// - Call and jump replace only the low eleven PC bits.
// - Add sums source byte and accumulator into the accumulator.
// - Carry from bit 7 sets carry, carry from bit 3 sets aux carry.
// - Overflow is set when exactly one of bit 6 and bit 7 carries.
// - Add with carry also adds the carry flag, flags as for add.
// - Both adds take register, direct, indirect or immediate source.
// - Byte AND writes the bitwise result to a RAM, port latch or accumulator destination (other registers are not written), flags untouched.
// - AND has six pairings: four into accumulator, two into direct byte.
// - AND into an output port reads the port latch; AND from port 1 into the accumulator reads the pins.

module call_jump_add_and_executor
   import cja_pkg::*;
#(
   parameter int RAM_DEPTH = 128
)
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Program memory
   output logic [15:0]      codeAddr,
   input  wire logic [7:0]  codeData,
   // Port pins, used only by reads that are not read-modify-write
   input  wire logic [7:0]  port1Pins,
   // Architectural state
   output logic [7:0]       accOut,
   output logic [15:0]      pcOut,
   output logic [7:0]       stackPointerOut,
   output logic             carryFlagOut,
   output logic             auxCarryFlagOut,
   output logic             overflowFlagOut,
   output logic [7:0]       port0LatchOut,
   output logic [7:0]       port1LatchOut,
   output logic [7:0]       port2LatchOut,
   output logic [7:0]       port3LatchOut,
   // Status
   output logic             instrDoneOut,
   output logic             illegalOut
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   exec_state_t stateReg;
   op_kind_t    opReg;
   src_kind_t   srcReg;
   logic [7:0]  opcodeReg;
   logic [7:0]  byte2Reg;
   logic [7:0]  byte3Reg;
   logic [1:0]  extraReg;
   logic [15:0] pcReg;
   logic [7:0]  accReg;
   logic [7:0]  spReg;
   logic        carryReg;
   logic        auxReg;
   logic        ovfReg;
   logic [7:0]  p0Reg;
   logic [7:0]  p1Reg;
   logic [7:0]  p2Reg;
   logic [7:0]  p3Reg;
   logic        doneReg;
   logic        illegalReg;
   logic [7:0]  ram [RAM_DEPTH];

   logic [15:0] pcNext;
   logic [7:0]  srcByte;
   logic [7:0]  dirAddr;
   logic [7:0]  dirRmw;
   logic [7:0]  sum;
   logic        sumCarry;
   logic        sumAux;
   logic        sumOvf;
   logic [7:0]  andResult;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Internal RAM read, limited to the implemented depth.
   function automatic logic [7:0] ramRead(input logic [7:0] addr);
      return (int'(addr) < RAM_DEPTH) ? ram[addr[6:0]] : 8'h00;
   endfunction

   // Direct byte read. Port latches stand in for port data so read-modify-write
   // sees what was last written, never the pin levels.
   function automatic logic [7:0] directRead(input logic [7:0] addr);
      logic [7:0] val;
      val = 8'h00;
      if (addr < `SFR_BASE) begin
         val = ramRead(addr);
      end else begin
         unique case (addr)
            `PORT0_ADDR: val = p0Reg;
            `PORT1_ADDR: val = p1Reg;
            `PORT2_ADDR: val = p2Reg;
            `PORT3_ADDR: val = p3Reg;
            8'hE0:       val = accReg;
            8'h81:       val = spReg;
            8'hD0:       val = {carryReg, auxReg, 3'h0, ovfReg, 2'h0};
            default:     val = 8'h00;
         endcase
      end
      return val;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Operand selection

   assign dirAddr = byte2Reg;

   always_comb begin
      unique case (srcReg)
         SRC_REG: srcByte = ramRead({5'h00, opcodeReg[2:0]});
         SRC_DIR: srcByte = (dirAddr == `PORT1_ADDR) ? port1Pins
                                                     : directRead(dirAddr);
         SRC_IND: srcByte = ramRead(ramRead({7'h00, opcodeReg[0]}));
         SRC_IMM: srcByte = byte2Reg;
      endcase
   end

   // A continuous assignment would only wake on the address, missing latch and
   // RAM updates read inside the function, so this read is a combinational process.
   always_comb begin
      dirRmw = directRead(dirAddr);
   end

   assign andResult = (opReg == OP_AND_A)  ? (accReg & srcByte)
                    : (opReg == OP_AND_DA) ? (dirRmw & accReg)
                    :                        (dirRmw & byte3Reg);

   byte_adder adder (
      .accIn    (accReg),
      .srcIn    (srcByte),
      .carryIn  ((opReg == OP_ADD_WITH_CARRY_OP) ? carryReg : 1'b0),
      .sumOut   (sum),
      .carryOut (sumCarry),
      .auxOut   (sumAux),
      .ovfOut   (sumOvf)
   );

   assign pcNext = pcReg;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: fetch, operand bytes, execute, second machine cycle

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stateReg   <= ST_FETCH;
         opReg      <= OP_NONE;
         srcReg     <= SRC_REG;
         opcodeReg  <= 8'h00;
         byte2Reg   <= 8'h00;
         byte3Reg   <= 8'h00;
         extraReg   <= 2'h0;
         doneReg    <= 1'b0;
         illegalReg <= 1'b0;
      end else begin
         doneReg <= 1'b0;
         unique case (stateReg)
            ST_FETCH: begin
               opcodeReg  <= codeData;
               illegalReg <= 1'b0;
               extraReg   <= 2'h0;
               stateReg   <= ST_EXEC;
               if (codeData[4:0] == `OPC_CALL_LOW5) begin
                  opReg <= OP_CALL;
                  extraReg <= 2'h1;
                  stateReg <= ST_OPERAND;
               end else if (codeData[4:0] == `OPC_JUMP_LOW5) begin
                  opReg <= OP_JUMP;
                  extraReg <= 2'h1;
                  stateReg <= ST_OPERAND;
               end else if (codeData[7:3] == `OPC_ADD_REG_HI5) begin
                  opReg <= OP_ADD;
                  srcReg <= SRC_REG;
               end else if (codeData[7:3] == `OPC_ADD_WITH_CARRY_OP_REG_HI5) begin
                  opReg <= OP_ADD_WITH_CARRY_OP;
                  srcReg <= SRC_REG;
               end else if (codeData[7:3] == `OPC_AND_REG_HI5) begin
                  opReg <= OP_AND_A;
                  srcReg <= SRC_REG;
               end else if (codeData[7:1] == `OPC_ADD_IND_HI7) begin
                  opReg <= OP_ADD;
                  srcReg <= SRC_IND;
               end else if (codeData[7:1] == `OPC_ADD_WITH_CARRY_OP_IND_HI7) begin
                  opReg <= OP_ADD_WITH_CARRY_OP;
                  srcReg <= SRC_IND;
               end else if (codeData[7:1] == `OPC_AND_IND_HI7) begin
                  opReg <= OP_AND_A;
                  srcReg <= SRC_IND;
               end else begin
                  stateReg <= ST_OPERAND;
                  extraReg <= 2'h1;
                  unique case (codeData)
                     `OPC_ADD_DIR:  begin opReg <= OP_ADD;  srcReg <= SRC_DIR; end
                     `OPC_ADD_IMM:  begin opReg <= OP_ADD;  srcReg <= SRC_IMM; end
                     `OPC_ADD_WITH_CARRY_OP_DIR: begin opReg <= OP_ADD_WITH_CARRY_OP; srcReg <= SRC_DIR; end
                     `OPC_ADD_WITH_CARRY_OP_IMM: begin opReg <= OP_ADD_WITH_CARRY_OP; srcReg <= SRC_IMM; end
                     `OPC_AND_DIR:  begin opReg <= OP_AND_A; srcReg <= SRC_DIR; end
                     `OPC_AND_IMM:  begin opReg <= OP_AND_A; srcReg <= SRC_IMM; end
                     `OPC_AND_DIR_A: begin opReg <= OP_AND_DA; srcReg <= SRC_DIR; end
                     `OPC_AND_DIR_IMM: begin
                        opReg    <= OP_AND_DI;
                        srcReg   <= SRC_DIR;
                        extraReg <= 2'h2;
                     end
                     default: begin
                        // Opcodes outside this slice are skipped as one byte.
                        opReg      <= OP_NONE;
                        illegalReg <= 1'b1;
                        extraReg   <= 2'h0;
                        stateReg   <= ST_FETCH;
                        doneReg    <= 1'b1;
                     end
                  endcase
               end
            end
            ST_OPERAND: begin
               if (extraReg == 2'h2) begin
                  byte2Reg <= codeData;
                  extraReg <= 2'h1;
               end else begin
                  if (opReg == OP_AND_DI) begin
                     byte3Reg <= codeData;
                  end else begin
                     byte2Reg <= codeData;
                  end
                  extraReg <= 2'h0;
                  stateReg <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               // Call, jump and AND of a constant into a direct byte need a
               // second machine cycle.
               if (opReg == OP_CALL || opReg == OP_JUMP
                   || opReg == OP_AND_DI) begin
                  stateReg <= ST_SECOND;
               end else begin
                  stateReg <= ST_FETCH;
                  doneReg  <= 1'b1;
               end
            end
            ST_SECOND: begin
               stateReg <= ST_FETCH;
               doneReg  <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Program counter

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pcReg <= `PC_RESET;
      end else if (stateReg == ST_FETCH || stateReg == ST_OPERAND) begin
         pcReg <= pcNext + 16'h0001;
      end else if (stateReg == ST_SECOND && (opReg == OP_CALL || opReg == OP_JUMP)) begin
         // The already advanced PC keeps its top five bits.
         pcReg <= {pcReg[15:`PAGE_BITS], opcodeReg[7:5], byte2Reg};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Accumulator and flags

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         accReg   <= `ACC_RESET;
         carryReg <= 1'b0;
         auxReg   <= 1'b0;
         ovfReg   <= 1'b0;
      end else if (stateReg == ST_EXEC) begin
         if (opReg == OP_ADD || opReg == OP_ADD_WITH_CARRY_OP) begin
            accReg   <= sum;
            carryReg <= sumCarry;
            auxReg   <= sumAux;
            ovfReg   <= sumOvf;
         end else if (opReg == OP_AND_A) begin
            accReg <= andResult;
         end else if ((opReg == OP_AND_DA) && (dirAddr == 8'hE0)) begin
            accReg <= andResult;
         end
      end else if (stateReg == ST_SECOND && opReg == OP_AND_DI && dirAddr == 8'hE0) begin
         accReg <= andResult;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Stack pointer, internal RAM and port latches

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         spReg <= `SP_RESET;
      end else if (opReg == OP_CALL
                   && (stateReg == ST_EXEC || stateReg == ST_SECOND)) begin
         spReg <= spReg + 8'h01;
      end
   end

   // Call pushes the return low byte in its first cycle and the high byte in
   // its second, so the low byte lands at the lower stack address.
   always_ff @(posedge ref_clk) begin
      if (opReg == OP_CALL && stateReg == ST_EXEC
          && int'(spReg + 8'h01) < RAM_DEPTH) begin
         ram[7'(spReg + 8'h01)] <= pcReg[7:0];
      end else if (opReg == OP_CALL && stateReg == ST_SECOND
                   && int'(spReg + 8'h01) < RAM_DEPTH) begin
         ram[7'(spReg + 8'h01)] <= pcReg[15:8];
      end else if (((opReg == OP_AND_DA && stateReg == ST_EXEC)
                    || (opReg == OP_AND_DI && stateReg == ST_SECOND))
                   && dirAddr < `SFR_BASE && int'(dirAddr) < RAM_DEPTH) begin
         ram[dirAddr[6:0]] <= andResult;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         p0Reg <= `PORT_RESET;
         p1Reg <= `PORT_RESET;
         p2Reg <= `PORT_RESET;
         p3Reg <= `PORT_RESET;
      end else if ((opReg == OP_AND_DA && stateReg == ST_EXEC)
                   || (opReg == OP_AND_DI && stateReg == ST_SECOND)) begin
         if (dirAddr == `PORT0_ADDR) p0Reg <= andResult;
         if (dirAddr == `PORT1_ADDR) p1Reg <= andResult;
         if (dirAddr == `PORT2_ADDR) p2Reg <= andResult;
         if (dirAddr == `PORT3_ADDR) p3Reg <= andResult;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         codeAddr <= `PC_RESET;
      end else begin
         codeAddr <= pcReg;
      end
   end

   assign accOut          = accReg;
   assign pcOut           = pcReg;
   assign stackPointerOut = spReg;
   assign carryFlagOut    = carryReg;
   assign auxCarryFlagOut = auxReg;
   assign overflowFlagOut = ovfReg;
   assign port0LatchOut   = p0Reg;
   assign port1LatchOut   = p1Reg;
   assign port2LatchOut   = p2Reg;
   assign port3LatchOut   = p3Reg;
   assign instrDoneOut    = doneReg;
   assign illegalOut      = illegalReg;

endmodule

// ==== call_jump_add_and_executor_props.sv ====
`timescale 1ns/1ns

module call_jump_add_and_executor_props
   import cja_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   // Watched state
   input wire logic [15:0] pcOut,
   input wire logic [7:0]  accOut,
   input wire logic [7:0]  stackPointerOut,
   input wire logic        carryFlagOut,
   input wire logic        auxCarryFlagOut,
   input wire logic        overflowFlagOut,
   input wire logic        instrDoneOut,
   input wire logic        illegalOut
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   logic [15:0] pcPrev;

   always_ff @(posedge ref_clk) begin
      pcPrev <= pcOut;
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_sp_step;
      $changed(stackPointerOut) |-> stackPointerOut == $past(stackPointerOut) + 8'h01;
   endproperty
   a_sp_step: assert property (p_sp_step) else $error("stack pointer moved by other than one");

   property p_sp_pair;
      $changed(stackPointerOut) && !instrDoneOut |=>
         stackPointerOut == $past(stackPointerOut) + 8'h01 && instrDoneOut;
   endproperty
   a_sp_pair: assert property (p_sp_pair) else $error("second push missing or late");

   // A taken branch may rewrite only the low eleven bits of the next address.
   property p_pc_block;
      pcOut != pcPrev && pcOut != pcPrev + 16'h0001 |-> pcOut[15:11] == pcPrev[15:11];
   endproperty
   a_pc_block: assert property (p_pc_block) else $error("branch left its 2K block");

   property p_flags_quiet;
      $changed(carryFlagOut) || $changed(auxCarryFlagOut) || $changed(overflowFlagOut)
         |-> instrDoneOut && !illegalOut;
   endproperty
   a_flags_quiet: assert property (p_flags_quiet) else $error("flags changed off an add");

   property p_acc_done;
      $changed(accOut) |-> ##[0:1] instrDoneOut;
   endproperty
   a_acc_done: assert property (p_acc_done) else $error("accumulator changed with no finish");

   property p_done_pulse;
      instrDoneOut |=> !instrDoneOut || illegalOut;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("finish pulse too long");

   property p_bad_pc;
      illegalOut && instrDoneOut |-> pcOut == $past(pcOut) + 16'h0001;
   endproperty
   a_bad_pc: assert property (p_bad_pc) else $error("unknown opcode not skipped as one byte");

   property p_bad_keep;
      $rose(illegalOut) |-> instrDoneOut && $stable(accOut) && $stable(stackPointerOut);
   endproperty
   a_bad_keep: assert property (p_bad_keep) else $error("unknown opcode changed state");
endmodule

bind call_jump_add_and_executor call_jump_add_and_executor_props u_props (
   .ref_clk         (ref_clk),
   .sys_rst         (sys_rst),
   .pcOut           (pcOut),
   .accOut          (accOut),
   .stackPointerOut (stackPointerOut),
   .carryFlagOut    (carryFlagOut),
   .auxCarryFlagOut (auxCarryFlagOut),
   .overflowFlagOut (overflowFlagOut),
   .instrDoneOut    (instrDoneOut),
   .illegalOut      (illegalOut)
);

// ==== tb.sv ====
`timescale 1ns/1ns

`define CHECK(what, exp, got) \
   begin \
      nTests++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end

module tb;
   import cja_pkg::*;

   typedef struct packed {
      logic        bad;
      logic [7:0]  acc;
      logic [15:0] pc;
      logic [7:0]  sp;
      logic [2:0]  flg;
      logic [31:0] prt;
      logic [7:0]  gap;
   } note_t;

   logic        ref_clk  = 1'b0;
   logic        sys_rst  = 1'b1;
   logic [7:0]  codeData = 8'h00;
   logic [7:0]  port1Pins;
   logic [7:0]  accOut;
   logic [15:0] pcOut;
   logic [7:0]  stackPointerOut;
   logic        carryFlagOut;
   logic        auxCarryFlagOut;
   logic        overflowFlagOut;
   logic [7:0]  port0LatchOut;
   logic [7:0]  port1LatchOut;
   logic [7:0]  port2LatchOut;
   logic [7:0]  port3LatchOut;
   logic        instrDoneOut;
   logic        illegalOut;
   logic [7:0]  rom [0:4095];
   logic [7:0]  mRam [0:127];
   logic [7:0]  mPort [0:3];
   logic [7:0]  dirs [0:4] = '{8'h90, 8'hD0, 8'hE0, 8'h81, 8'h03};
   logic [7:0]  fam [0:2] = '{8'h20, 8'h30, 8'h50};
   logic [7:0]  mAcc;
   logic [15:0] mPc;
   logic [7:0]  mSp;
   logic        mC;
   logic        mAc;
   logic        mOv;
   logic        mBad;
   note_t       q [$];
   note_t       e;
   logic [7:0]  gap = 8'h00;
   bit          seen = 1'b0;
   int          failures = 0;
   int          nTests = 0;

   always #4 ref_clk = ~ref_clk;

   // The program store answers at once, like an asynchronous ROM.
   always @(posedge ref_clk) begin
      #1;
      codeData = rom[pcOut[11:0]];
   end

   call_jump_add_and_executor #(.RAM_DEPTH(128)) u_call_jump_add_and_executor (
      .ref_clk         (ref_clk),
      .sys_rst         (sys_rst),
      .codeAddr        (),
      .codeData        (codeData),
      .port1Pins       (port1Pins),
      .accOut          (accOut),
      .pcOut           (pcOut),
      .stackPointerOut (stackPointerOut),
      .carryFlagOut    (carryFlagOut),
      .auxCarryFlagOut (auxCarryFlagOut),
      .overflowFlagOut (overflowFlagOut),
      .port0LatchOut   (port0LatchOut),
      .port1LatchOut   (port1LatchOut),
      .port2LatchOut   (port2LatchOut),
      .port3LatchOut   (port3LatchOut),
      .instrDoneOut    (instrDoneOut),
      .illegalOut      (illegalOut)
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rd(input logic [7:0] a, input bit rmw);
      if (a < 8'h80) return mRam[a[6:0]];
      case (a)
         8'hE0: return mAcc;
         8'h81: return mSp;
         8'hD0: return {mC, mAc, 3'b000, mOv, 2'b00};
         8'h90: return rmw ? mPort[1] : port1Pins;
         8'h80, 8'hA0, 8'hB0: return mPort[a[5:4]];
         default: return 8'h00;
      endcase
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      if (a < 8'h80) mRam[a[6:0]] = v;
      else if (a inside {8'h80, 8'h90, 8'hA0, 8'hB0}) mPort[a[5:4]] = v;
   endtask

   task automatic put(input logic [7:0] b);
      rom[mPc[11:0]] = b;
      mPc = mPc + 16'h0001;
   endtask

   task automatic note(input logic [7:0] g);
      q.push_back('{mBad, mAcc, mPc, mSp, {mC, mAc, mOv},
                   {mPort[0], mPort[1], mPort[2], mPort[3]}, g});
   endtask

   // Add, add with carry or AND into the accumulator; k picks the source kind.
   task automatic alu(input logic [7:0] base, input int k, input logic [7:0] x);
      logic [7:0] v;
      logic [8:0] r;
      logic       ci;
      logic       c6;
      case (k)
         0: v = mRam[x[2:0]];
         1: v = rd(x, 1'b0);
         2: v = mRam[mRam[x[0]][6:0]];
         default: v = x;
      endcase
      put(base | (k == 0 ? 8'h08 | x : k == 1 ? 8'h05 : k == 2 ? 8'h06 | x : 8'h04));
      if (k[0]) put(x);
      ci = (base == 8'h30) & mC;
      if (base == 8'h50) begin
         mAcc = mAcc & v;
      end else begin
         r = {1'b0, mAcc} + {1'b0, v} + {8'h00, ci};
         mAc = ({1'b0, mAcc[3:0]} + {1'b0, v[3:0]} + {4'h0, ci}) > 5'h0F;
         c6 = ({1'b0, mAcc[6:0]} + {1'b0, v[6:0]} + {7'h00, ci}) > 8'h7F;
         mOv = r[8] ^ c6;
         mC = r[8];
         mAcc = r[7:0];
      end
      note(k[0] ? 8'h03 : 8'h02);
   endtask

   task automatic andd(input logic [7:0] a, input bit imm, input logic [7:0] d);
      logic [7:0] v;
      v = rd(a, 1'b1) & (imm ? d : mAcc);
      put(imm ? 8'h53 : 8'h52);
      put(a);
      if (imm) put(d);
      wr(a, v);
      note(imm ? 8'h05 : 8'h03);
   endtask

   task automatic branch(input bit call, input logic [10:0] t);
      put({t[10:8], call, 4'h1});
      put(t[7:0]);
      if (call) begin
         mSp = mSp + 8'h01;
         mRam[mSp[6:0]] = mPc[7:0];
         mSp = mSp + 8'h01;
         mRam[mSp[6:0]] = mPc[15:8];
      end
      mPc = {mPc[15:11], t};
      note(8'h04);
   endtask

   task automatic bad(input logic [7:0] b);
      put(b);
      mBad = 1'b1;
      note(8'h01);
      mBad = 1'b0;
   endtask

   task printVerdict;
      if (failures == 0 && nTests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge ref_clk) begin
      gap = gap + 8'h01;
      if (!sys_rst && instrDoneOut === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         `CHECK("acc", e.acc, accOut)
         `CHECK("flags", e.flg, {carryFlagOut, auxCarryFlagOut, overflowFlagOut})
         `CHECK("pc", e.pc, pcOut)
         `CHECK("sp", e.sp, stackPointerOut)
         `CHECK("ports", e.prt, {port0LatchOut, port1LatchOut, port2LatchOut, port3LatchOut})
         `CHECK("illegal", e.bad, illegalOut)
         if (seen) `CHECK("cycles", e.gap, gap)
         seen = 1'b1;
         gap = 8'h00;
      end
   end

   // The whole program and its expectations are built before reset lifts.
   initial begin
      int k;
      logic [7:0] x;
      void'($urandom(32'hCB5FDBEB));
      port1Pins = 8'($urandom);
      // Opcode 00 lies outside the slice, so running past the program only skips bytes.
      foreach (rom[i]) rom[i] = 8'h00;
      mPc = 16'h0000;
      mAcc = 8'h00;
      mSp = 8'h07;
      mC = 1'b0;
      mAc = 1'b0;
      mOv = 1'b0;
      mBad = 1'b0;
      mPort = '{default: 8'hFF};
      // Working registers power up unknown; clearing them is the only way to know them.
      for (int i = 0; i < 8; i++) andd(8'(i), 1'b1, 8'h00);
      alu(8'h20, 3, 8'hC3);
      alu(8'h20, 3, 8'hAA);
      alu(8'h30, 3, 8'hFF);
      for (int i = 0; i < 36; i++) begin
         k = i % 4;
         x = k == 0 ? 8'($urandom % 8) : k == 2 ? 8'($urandom % 2) :
             k == 1 ? dirs[$urandom % 5] : 8'($urandom);
         alu(fam[(i / 4) % 3], k, x);
      end
      andd(8'h90, 1'b1, 8'($urandom));
      alu(8'h50, 1, 8'h90);
      andd(8'h90, 1'b0, 8'h00);
      andd(8'hB0, 1'b0, 8'h00);
      bad(8'h00);
      bad(8'hA5);
      branch(1'b0, 11'h7FC);
      alu(8'h20, 3, 8'($urandom));
      branch(1'b1, 11'h123);
      alu(8'h50, 3, 8'h00);
      alu(8'h20, 1, 8'h08);
      alu(8'h20, 1, 8'h09);
      branch(1'b0, 11'h5A0);
      branch(1'b1, 11'h400);
      alu(8'h20, 1, 8'h0B);
      repeat (16) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      for (int i = 0; i < 3000 && q.size() > 0; i++) @(posedge ref_clk);
      if (q.size() > 0) failures++;
      printVerdict();
   end
endmodule
